/* File: hw/pcrc_app.sv */
module pcrc_app
   import pcrc_pkg::*;
(
   input  wire logic i_mclk,
   input  wire logic i_rstn,
   pcrc_if.app       lnk,
   input  wire logic i_has_sideband,
   input  wire logic i_board_rst_n,
   input  wire logic i_warm_req,
   output logic      o_app_rst,
   output logic      o_flr_busy
);

   logic [5:0]           por_cnt_q;
   logic                 por_done_q;
   logic [4:0]           warm_cnt_q;
   logic [3:0]           work_cnt_q;
   logic [NPF-1:0]       pf_done_q;
   logic [NVF-1:0]       vf_done_q;
   logic                 work_open;

   // local power-on reset when no sideband reset exists
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         por_cnt_q  <= '0;
         por_done_q <= 1'b0;
      end
      else if (por_cnt_q == 6'(POR_CYC - 1))
         por_done_q <= 1'b1;
      else
         por_cnt_q <= por_cnt_q + 6'h01;
   end

   // warm reset request stretched to a fixed width
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
         warm_cnt_q <= '0;
      else if (i_warm_req)
         warm_cnt_q <= 5'(WARM_CYC);
      else if (warm_cnt_q != 5'h00)
         warm_cnt_q <= warm_cnt_q - 5'h01;
   end

   // fundamental reset drive, asserted for cold and warm alike
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
         lnk.sys_rst_n <= 1'b0;
      else
         lnk.sys_rst_n <= por_done_q & (warm_cnt_q == 5'h00) & ~i_warm_req
                          & (i_board_rst_n | ~i_has_sideband);
   end

   // application logic reset follows user and hot reset
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
         o_app_rst <= 1'b1;
      else
         o_app_rst <= lnk.user_reset | lnk.hot_reset;
   end

   // function cleanup: fixed work time, far inside the FLR limit
   assign work_open = |(lnk.pf_reset_pending & ~pf_done_q) | |(lnk.vf_reset_pending & ~vf_done_q);

   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn || lnk.user_reset || lnk.hot_reset)
      begin
         work_cnt_q <= '0;
         pf_done_q  <= '0;
         vf_done_q  <= '0;
      end
      else if (work_open && work_cnt_q == 4'(FLR_WORK_CYC - 1))
      begin
         work_cnt_q <= '0;
         pf_done_q  <= lnk.pf_reset_pending;
         vf_done_q  <= lnk.vf_reset_pending;
      end
      else
      begin
         work_cnt_q <= work_open ? work_cnt_q + 4'h1 : 4'h0;
         pf_done_q  <= pf_done_q & lnk.pf_reset_pending;
         vf_done_q  <= vf_done_q & lnk.vf_reset_pending;
      end
   end
   assign lnk.pf_reset_complete = pf_done_q;
   assign lnk.vf_reset_complete = vf_done_q;

   // busy flag for the application's own use
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
         o_flr_busy <= 1'b0;
      else
         o_flr_busy <= work_open;
   end

endmodule : pcrc_app

/* File: hw/pcrc_dev.sv */
// Operation
// - fundamental reset is async active low
// - fundamental reset hard-resets core and transceivers
// - after release, core trains link autonomously
// - cold and warm resets use fundamental reset
// - hot reset resets endpoint, raises indication
// - FLR sets matching pf/vf pending bit
// - application raises matching reset-complete bit
// - drop traffic of function under FLR silently
// - FLR must finish within 100 ms
// - user reset asserted with fundamental reset
// - user reset asserted on core PLL loss
// - user reset asserted on transceiver PLL loss
// - user reset released synchronously after all clear
// - without sideband, generate initial reset locally
//
// Added by the designer: the address map and the APB register port.
module pcrc_dev
   import pcrc_pkg::*;
#(
   parameter int P_FLR_LIMIT_CYC = FLR_LIMIT_CYC
)(
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   pcrc_if.dev              lnk,
   input  wire logic        i_core_pll_lock,
   input  wire logic [3:0]  i_xcvr_pll_lock,
   input  wire logic        i_link_up,
   input  wire logic        i_hot_evt,
   input  wire logic        i_flr_evt,
   input  wire logic        i_flr_vf,
   input  wire logic [1:0]  i_flr_fn,
   input  wire logic        i_tlp_valid,
   input  wire logic        i_tlp_vf,
   input  wire logic [1:0]  i_tlp_fn,
   output logic             o_tlp_valid,
   output logic             o_tlp_drop,
   output logic             o_xcvr_rst,
   output logic             o_core_rst,
   output logic             o_link_train,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr,
   output logic             o_irq
);

   logic                  frst_meta_q;
   logic                  frst_q;
   logic                  urst_meta_q;
   logic                  urst_q;
   logic                  usr_ok_n;
   logic                  core_rst;
   pcrc_state_e           state_q;
   logic [4:0]            hot_cnt_q;
   logic [NPF-1:0]        pf_pend_q;
   logic [NVF-1:0]        vf_pend_q;
   logic [19:0]           flr_cnt_q;
   logic                  tmo_done_q;
   logic                  core_lock_q;
   logic                  xcvr_lock_q;
   logic [1:0]            ctrl_q;
   logic [EV_W-1:0]       status_q;
   logic [EV_W-1:0]       mask_q;
   logic [EV_W-1:0]       ev_set;
   logic [EV_W-1:0]       ev_clr;
   logic                  acc;
   logic                  wr_hit;

   // true when the addressed function has its reset pending
   function automatic logic fn_pending(input logic vf, input logic [1:0] fn,
                                       input logic [NPF-1:0] pf_p, input logic [NVF-1:0] vf_p);
      if (vf)
         fn_pending = vf_p[fn];
      else
         fn_pending = (fn < 2'(NPF)) ? pf_p[fn[0]] : 1'b0;
   endfunction : fn_pending

   // fundamental reset: async assert, sync release, feeds hard reset
   always_ff @(posedge i_mclk or negedge lnk.sys_rst_n)
   begin
      if (!lnk.sys_rst_n)
      begin
         frst_meta_q <= 1'b1;
         frst_q      <= 1'b1;
      end
      else
      begin
         frst_meta_q <= 1'b0;
         frst_q      <= frst_meta_q;
      end
   end

   // any fundamental reset, cold or warm, arrives the same way
   assign core_rst = frst_q | ~i_rstn;
   assign o_xcvr_rst = frst_q;

   // user reset conditions; a lock loss must not wait for a clock edge
   assign usr_ok_n = lnk.sys_rst_n & i_core_pll_lock & (&i_xcvr_pll_lock);

   // user reset: asserted asynchronously, released through two flops
   always_ff @(posedge i_mclk or negedge usr_ok_n)
   begin
      if (!usr_ok_n)
      begin
         urst_meta_q <= 1'b1;
         urst_q      <= 1'b1;
      end
      else if (!i_rstn)
      begin
         urst_meta_q <= 1'b1;
         urst_q      <= 1'b1;
      end
      else
      begin
         urst_meta_q <= 1'b0;
         urst_q      <= urst_meta_q;
      end
   end
   assign lnk.user_reset = urst_q;

   // link state: hard reset, training, up, in-band hot reset
   always_ff @(posedge i_mclk)
   begin
      if (core_rst)
      begin
         state_q   <= ST_HARD;
         hot_cnt_q <= '0;
      end
      else
      begin
         case (state_q)
            ST_HARD:  state_q <= ST_TRAIN;
            ST_TRAIN: if (i_link_up) state_q <= ST_UP;
            ST_UP:
            begin
               if (i_hot_evt)
               begin
                  state_q   <= ST_HOT;
                  hot_cnt_q <= '0;
               end
            end
            ST_HOT:
            begin
               if (hot_cnt_q == 5'(HOT_CYC - 1))
                  state_q <= ST_TRAIN;
               hot_cnt_q <= hot_cnt_q + 5'h01;
            end
            default:  state_q <= ST_HARD;
         endcase
      end
   end

   // registered link-side outputs derived from state
   always_ff @(posedge i_mclk)
   begin
      if (core_rst)
      begin
         o_core_rst     <= 1'b1;
         o_link_train   <= 1'b0;
         lnk.hot_reset  <= 1'b0;
      end
      else
      begin
         o_core_rst     <= (state_q == ST_HARD) || (state_q == ST_HOT);
         o_link_train   <= (state_q == ST_TRAIN);
         lnk.hot_reset  <= (state_q == ST_HOT);
      end
   end

   // per-function pending bits; a new FLR wins over a completion
   always_ff @(posedge i_mclk)
   begin
      if (core_rst || state_q == ST_HOT)
      begin
         pf_pend_q <= '0;
         vf_pend_q <= '0;
      end
      else
      begin
         pf_pend_q <= pf_pend_q & ~lnk.pf_reset_complete;
         vf_pend_q <= vf_pend_q & ~lnk.vf_reset_complete;
         if (i_flr_evt && !i_flr_vf && i_flr_fn < 2'(NPF))
            pf_pend_q[i_flr_fn[0]] <= 1'b1;
         if (i_flr_evt && i_flr_vf)
            vf_pend_q[i_flr_fn] <= 1'b1;
      end
   end
   assign lnk.pf_reset_pending = pf_pend_q;
   assign lnk.vf_reset_pending = vf_pend_q;

   // traffic to a function under reset vanishes, no error raised
   always_ff @(posedge i_mclk)
   begin
      if (core_rst)
      begin
         o_tlp_valid <= 1'b0;
         o_tlp_drop  <= 1'b0;
      end
      else
      begin
         o_tlp_valid <= i_tlp_valid & ~fn_pending(i_tlp_vf, i_tlp_fn, pf_pend_q, vf_pend_q);
         o_tlp_drop  <= i_tlp_valid & fn_pending(i_tlp_vf, i_tlp_fn, pf_pend_q, vf_pend_q);
      end
   end

   // watchdog over outstanding FLRs; one timer shared, restarts when idle
   always_ff @(posedge i_mclk)
   begin
      if (core_rst || ((pf_pend_q == '0) && (vf_pend_q == '0)))
      begin
         flr_cnt_q  <= '0;
         tmo_done_q <= 1'b0;
      end
      else if (flr_cnt_q == 20'(P_FLR_LIMIT_CYC - 1))
         tmo_done_q <= 1'b1;
      else
         flr_cnt_q <= flr_cnt_q + 20'h00001;
   end

   // lock history for loss edges
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         core_lock_q <= 1'b0;
         xcvr_lock_q <= 1'b0;
      end
      else
      begin
         core_lock_q <= i_core_pll_lock;
         xcvr_lock_q <= &i_xcvr_pll_lock;
      end
   end

   // event sources for the sticky status bits
   always_comb
   begin
      ev_set              = '0;
      ev_set[EV_HOT]      = (state_q == ST_UP) & i_hot_evt & ~core_rst;
      ev_set[EV_FLR_PF]   = i_flr_evt & ~i_flr_vf & ~core_rst;
      ev_set[EV_FLR_VF]   = i_flr_evt & i_flr_vf & ~core_rst;
      ev_set[EV_CORE_PLL] = core_lock_q & ~i_core_pll_lock;
      ev_set[EV_XCVR_PLL] = xcvr_lock_q & ~(&i_xcvr_pll_lock);
      ev_set[EV_FLR_TMO]  = ctrl_q[CTRL_TMO_EN] & ~tmo_done_q & ~core_rst
                            & (flr_cnt_q == 20'(P_FLR_LIMIT_CYC - 1));
      ev_set[EV_TRAIN]    = (state_q == ST_HARD) & ~core_rst;
   end

   // apb: access completes on the second access-phase edge
   assign acc    = psel & penable;
   assign wr_hit = acc & o_pready & pwrite;
   assign ev_clr = (wr_hit && paddr == REG_STATUS) ? pwdata[EV_W-1:0] : '0;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         o_pready  <= 1'b0;
         o_prdata  <= '0;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready  <= acc & ~o_pready;
         o_pslverr <= 1'b0;
         o_prdata  <= '0;
         if (acc && !o_pready)
         begin
            if (paddr == REG_CTRL)
               o_prdata <= {30'h0, ctrl_q};
            else if (paddr == REG_STATUS)
               o_prdata <= {25'h0, status_q};
            else if (paddr == REG_MASK)
               o_prdata <= {25'h0, mask_q};
            else if (paddr == REG_STATE)
               o_prdata <= {16'h0, vf_pend_q, pf_pend_q, 3'h0, urst_q, frst_q, 1'b0, state_q};
            else
               o_pslverr <= 1'b1;
            if (pwrite)
               o_prdata <= '0;
         end
      end
   end

   // writable registers, updated at the completing edge
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         ctrl_q <= CTRL_RST;
         mask_q <= MASK_RST;
      end
      else if (wr_hit && paddr == REG_CTRL)
         ctrl_q <= pwdata[1:0];
      else if (wr_hit && paddr == REG_MASK)
         mask_q <= pwdata[EV_W-1:0];
   end

   // sticky status: set beats a simultaneous write-one clear
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
         status_q <= '0;
      else
         status_q <= (status_q & ~ev_clr) | ev_set;
   end

   // level interrupt while any unmasked bit is set
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
         o_irq <= 1'b0;
      else
         o_irq <= |(((status_q & ~ev_clr) | ev_set) & mask_q);
   end

endmodule : pcrc_dev

/* File: hw/pcrc_if.sv */
interface pcrc_if;
   import pcrc_pkg::*;
   logic           sys_rst_n;         // fundamental reset, active low, async
   logic           user_reset;        // application reset, active high
   logic           hot_reset;         // in-band hot reset indication
   logic [NPF-1:0] pf_reset_pending;
   logic [NVF-1:0] vf_reset_pending;
   logic [NPF-1:0] pf_reset_complete;
   logic [NVF-1:0] vf_reset_complete;

   modport dev (
      input  sys_rst_n,
      input  pf_reset_complete,
      input  vf_reset_complete,
      output user_reset,
      output hot_reset,
      output pf_reset_pending,
      output vf_reset_pending
   );

   modport app (
      output sys_rst_n,
      output pf_reset_complete,
      output vf_reset_complete,
      input  user_reset,
      input  hot_reset,
      input  pf_reset_pending,
      input  vf_reset_pending
   );
endinterface : pcrc_if

/* File: hw/pcrc_pkg.sv */
package pcrc_pkg;
   // link-side widths
   localparam int NPF = 2;
   localparam int NVF = 4;

   // clock and timing
   localparam longint CLK_HZ        = 10_000_000;
   localparam int     FLR_LIMIT_MS  = 100;
   localparam int     FLR_LIMIT_CYC = int'((longint'(FLR_LIMIT_MS) * CLK_HZ) / 1000);
   localparam int     HOT_CYC       = 16;
   localparam int     POR_CYC       = 32;
   localparam int     WARM_CYC      = 16;
   localparam int     FLR_WORK_CYC  = 8;

   // register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_MASK   = 8'h08;
   localparam logic [7:0] REG_STATE  = 8'h0c;

   // status and mask bit positions
   localparam int EV_HOT      = 0;
   localparam int EV_FLR_PF   = 1;
   localparam int EV_FLR_VF   = 2;
   localparam int EV_CORE_PLL = 3;
   localparam int EV_XCVR_PLL = 4;
   localparam int EV_FLR_TMO  = 5;
   localparam int EV_TRAIN    = 6;
   localparam int EV_W        = 7;

   // ctrl bit positions, ctrl and mask reset values
   localparam int                 CTRL_TMO_EN = 0;
   localparam logic [1:0]         CTRL_RST    = 2'h1;
   localparam logic [EV_W-1:0]    MASK_RST    = 7'h00;

   // link state machine, one-hot
   typedef enum logic [3:0] {
      ST_HARD  = 4'h1,
      ST_TRAIN = 4'h2,
      ST_UP    = 4'h4,
      ST_HOT   = 4'h8
   } pcrc_state_e;
endpackage : pcrc_pkg

/* File: test/pcrc_monitor.sv */
module pcrc_monitor
   import pcrc_pkg::*;
(
   input wire logic           i_mclk,
   input wire logic           i_rstn,
   input wire logic           sys_rst_n,
   input wire logic           user_reset,
   input wire logic           hot_reset,
   input wire logic [NPF-1:0] pf_reset_pending,
   input wire logic [NVF-1:0] vf_reset_pending,
   input wire logic [NPF-1:0] pf_reset_complete,
   input wire logic [NVF-1:0] vf_reset_complete
);
   timeunit 1ns;
   timeprecision 1ns;

   // single domain, so one clock and one disable serve all
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);

   // app reset must never trail the fundamental reset
   a_urst_on_frst: assert property (!sys_rst_n |-> user_reset)
      else $error("user reset low while fundamental reset low");
   a_urst_late_rel: assert property ($fell(user_reset) |-> sys_rst_n && $past(sys_rst_n))
      else $error("user reset released too early");
   // hot pulse is exactly sixteen cycles, two runs of eight then low
   a_hot_pulse_len: assert property ($rose(hot_reset) |-> hot_reset [*8] ##1 hot_reset [*8] ##1 !hot_reset)
      else $error("hot reset pulse length wrong");
   a_por_hold: assert property ($rose(i_rstn) |-> !sys_rst_n [*8])
      else $error("power-on reset too short");
   // pending drops on the edge after its completion
   a_pf_pend_clr: assert property ((pf_reset_pending & pf_reset_complete) != '0 |=>
      (pf_reset_pending & $past(pf_reset_complete)) == '0)
      else $error("pf pending not cleared after completion");
   a_vf_pend_clr: assert property ((vf_reset_pending & vf_reset_complete) != '0 |=>
      (vf_reset_pending & $past(vf_reset_complete)) == '0)
      else $error("vf pending not cleared after completion");
   a_pf_done_soon: assert property ($rose(|pf_reset_pending) |-> ##[1:12] |pf_reset_complete)
      else $error("pf completion missing");
   a_vf_done_soon: assert property ($rose(|vf_reset_pending) |-> ##[1:12] |vf_reset_complete)
      else $error("vf completion missing");

   c_hot: cover property ($rose(hot_reset));
   c_vf_done: cover property ($fell(|vf_reset_pending));
   c_urst_rel: cover property ($fell(user_reset));
endmodule : pcrc_monitor

/* File: test/test_pcie_core_reset_control.sv */
module test_pcie_core_reset_control;
   import pcrc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic        i_mclk, i_rstn, i_core_pll_lock, i_link_up, i_hot_evt, i_flr_evt, i_flr_vf;
   logic        i_tlp_valid, i_tlp_vf, i_warm_req, psel, penable, pwrite;
   logic [3:0]  i_xcvr_pll_lock;
   logic [1:0]  i_flr_fn, i_tlp_fn;
   logic [7:0]  paddr;
   logic [31:0] pwdata, o_prdata;
   logic        o_tlp_valid, o_tlp_drop, o_xcvr_rst, o_core_rst, o_link_train;
   logic        o_pready, o_pslverr, o_irq, o_app_rst;
   logic        i_has_sideband, i_board_rst_n, o_flr_busy;
   int          num_errors, check_count;

   pcrc_if lnk ();

   pcrc_dev #(.P_FLR_LIMIT_CYC(50)) u_pcrc_dev (.i_mclk, .i_rstn, .lnk, .i_core_pll_lock, .i_xcvr_pll_lock,
      .i_link_up, .i_hot_evt, .i_flr_evt, .i_flr_vf, .i_flr_fn, .i_tlp_valid, .i_tlp_vf, .i_tlp_fn,
      .o_tlp_valid, .o_tlp_drop, .o_xcvr_rst, .o_core_rst, .o_link_train, .psel, .penable, .pwrite,
      .paddr, .pwdata, .o_pready, .o_prdata, .o_pslverr, .o_irq);

   // sideband off at boot, so the app end makes its own power-on reset
   pcrc_app u_pcrc_app (.i_mclk, .i_rstn, .lnk, .i_has_sideband, .i_board_rst_n,
      .i_warm_req, .o_app_rst, .o_flr_busy);

   pcrc_monitor u_pcrc_monitor (.i_mclk, .i_rstn, .sys_rst_n(lnk.sys_rst_n), .user_reset(lnk.user_reset),
      .hot_reset(lnk.hot_reset), .pf_reset_pending(lnk.pf_reset_pending),
      .vf_reset_pending(lnk.vf_reset_pending), .pf_reset_complete(lnk.pf_reset_complete),
      .vf_reset_complete(lnk.vf_reset_complete));

   // 100 ns clock
   initial
   begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end

   task automatic final_report();
      if (num_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // watched levels for the bounded waits
   function automatic logic sig(input int s);
      case (s)
         0: return lnk.user_reset;
         1: return o_link_train;
         2: return lnk.hot_reset;
         3: return |{lnk.pf_reset_pending, lnk.vf_reset_pending};
         default: return !lnk.sys_rst_n;
      endcase
   endfunction : sig

   task automatic wt(input int s, input logic v);
      int n;
      n = 0;
      while (sig(s) !== v && n < 300)
      begin
         @(posedge i_mclk);
         n++;
      end
      if (n == 300)
      begin
         chk(sig(s), v);
         final_report();
      end
   endtask : wt

   // apb cycle; a spare edge at the end keeps back-to-back calls legal
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge i_mclk);
         n++;
      end
      while (o_pready !== 1'b1 && n < 20);
      r = o_prdata;
      e = o_pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20)
      begin
         chk(o_pready, 1'b1);
         final_report();
      end
      else
         @(posedge i_mclk);
   endtask : apb

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask : rd

   task automatic wr_irq(input logic [7:0] a, input logic [31:0] d, input logic exp);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      repeat (2) @(posedge i_mclk);
      chk(o_irq, exp);
   endtask : wr_irq

   task automatic up();
      logic [31:0] r;
      wt(0, 1'b0);
      wt(1, 1'b1);
      i_link_up <= 1'b1;
      repeat (3) @(posedge i_mclk);
      rd(REG_STATE, r);
      chk({r[6], r[3:0]}, {1'b0, ST_UP});
   endtask : up

   task automatic t_boot();
      logic [31:0] r;
      logic        e;
      @(posedge i_mclk);
      chk(lnk.user_reset, 1'b1);
      chk(o_xcvr_rst, 1'b1);
      up();
      rd(REG_CTRL, r);
      chk(r, {30'h0, CTRL_RST});
      rd(REG_MASK, r);
      chk(r, {25'h0, MASK_RST});
      // write path of the control word, and write returns zero data
      apb(1'b1, REG_CTRL, 32'h0, r, e);
      chk(r, 32'h0);
      rd(REG_CTRL, r);
      chk(r, 32'h0);
      rd(REG_STATUS, r);
      chk(r[EV_TRAIN], 1'b1);
      apb(1'b1, 8'h40, 32'hffff_ffff, r, e);
      chk(e, 1'b1);
      wr_irq(REG_STATUS, 32'h7f, 1'b0);
   endtask : t_boot

   task automatic t_pll();
      logic [31:0] r;
      i_xcvr_pll_lock <= 4'hb;
      repeat (3) @(posedge i_mclk);
      chk(lnk.user_reset, 1'b1);
      i_xcvr_pll_lock <= 4'hf;
      wt(0, 1'b0);
      i_core_pll_lock <= 1'b0;
      repeat (3) @(posedge i_mclk);
      chk({lnk.user_reset, o_app_rst}, 2'h3);
      i_core_pll_lock <= 1'b1;
      wt(0, 1'b0);
      rd(REG_STATUS, r);
      chk(r[4:3], 2'h3);
      // raise, mask, unmask, then clear the sticky bit
      wr_irq(REG_MASK, 32'h08, 1'b1);
      wr_irq(REG_MASK, 32'h00, 1'b0);
      wr_irq(REG_MASK, 32'h08, 1'b1);
      wr_irq(REG_STATUS, 32'h08, 1'b0);
   endtask : t_pll

   // one reset of one function, with traffic to it and to a neighbour
   task automatic t_flr(input logic vf, input logic [1:0] fn);
      logic [5:0] exp;
      exp = vf ? {2'h0, 4'h1 << fn} : {2'h1 << fn, 4'h0};
      i_flr_evt <= 1'b1;
      i_flr_vf <= vf;
      i_flr_fn <= fn;
      @(posedge i_mclk);
      i_flr_evt <= 1'b0;
      i_tlp_valid <= 1'b1;
      i_tlp_vf <= vf;
      i_tlp_fn <= fn;
      @(posedge i_mclk);
      chk({lnk.pf_reset_pending, lnk.vf_reset_pending}, exp);
      i_tlp_fn <= fn ^ 2'h1;
      @(posedge i_mclk);
      chk({o_tlp_valid, o_tlp_drop}, 2'h1);
      chk(o_flr_busy, 1'b1);
      i_tlp_valid <= 1'b0;
      @(posedge i_mclk);
      chk({o_tlp_valid, o_tlp_drop}, 2'h2);
      wt(3, 1'b0);
      @(posedge i_mclk);
      chk(o_flr_busy, 1'b0);
   endtask : t_flr

   task automatic t_hot();
      logic [31:0] r;
      i_hot_evt <= 1'b1;
      @(posedge i_mclk);
      i_hot_evt <= 1'b0;
      wt(2, 1'b1);
      chk({o_core_rst, lnk.sys_rst_n}, 2'h3);
      i_link_up <= 1'b0;
      wt(2, 1'b0);
      up();
      rd(REG_STATUS, r);
      chk(r[EV_HOT], 1'b1);
   endtask : t_hot

   task automatic t_warm();
      i_warm_req <= 1'b1;
      @(posedge i_mclk);
      i_warm_req <= 1'b0;
      wt(4, 1'b1);
      i_link_up <= 1'b0;
      @(posedge i_mclk);
      chk({lnk.user_reset, o_xcvr_rst, o_core_rst}, 3'h7);
      up();
   endtask : t_warm

   // board sideband reset pulled low for two cycles, then released
   task automatic t_side();
      i_has_sideband <= 1'b1;
      i_board_rst_n <= 1'b0;
      wt(4, 1'b1);
      i_link_up <= 1'b0;
      i_board_rst_n <= 1'b1;
      @(posedge i_mclk);
      chk({lnk.user_reset, o_xcvr_rst}, 2'h3);
      up();
   endtask : t_side

   initial
   begin
      {i_hot_evt, i_flr_evt, i_flr_vf, i_tlp_valid, i_tlp_vf, i_warm_req, i_link_up} = 7'h00;
      {psel, penable, pwrite, i_rstn} = 4'h0;
      {i_has_sideband, i_board_rst_n} = 2'h1;
      {i_flr_fn, i_tlp_fn, paddr, pwdata} = '0;
      i_core_pll_lock = 1'b1;
      i_xcvr_pll_lock = 4'hf;
      num_errors = 0;
      check_count = 0;
      repeat (2) @(posedge i_mclk);
      i_rstn <= 1'b1;
      t_boot();
      t_pll();
      for (int k = 0; k < 6; k++)
         t_flr(1'(k >= 2), 2'(k >= 2 ? k - 2 : k));
      t_hot();
      t_warm();
      t_side();
      final_report();
   end
endmodule : test_pcie_core_reset_control
